// file: include/exc_seq_regs.svh
`ifndef EXC_SEQ_REGS_SVH
`define EXC_SEQ_REGS_SVH
`define FRAME_SIZE 32'h0000_0020
`define FRAME_WORDS 4'h8
`define ALIGN_BIT 2
`define REALIGN_PSR_BIT 9
`define RET_TAG 4'hF
`define RET_HANDLER_MAIN 4'h1
`define RET_THREAD_MAIN 4'h9
`define RET_THREAD_PROC 4'hD
`define EXC_NMI 6'h02
`define EXC_HARD_FAULT 6'h03
`define EXC_SUPERVISOR_CALL 6'h0B
`define EXC_PENDABLE_SERVICE 6'h0E
`define EXC_TICK_TIMER 6'h0F
`define EXC_FIRST_EXTERNAL 6'h10
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_MSP 8'h08
`define REG_PSP 8'h0C
`define REG_VECTOR_BASE_REGISTER 8'h10
`define REG_PSR 8'h14
`define REG_EXC_REQ 8'h18
`define REG_RET_REQ 8'h1C
`define REG_ACTIVE_LO 8'h20
`define REG_ACTIVE_HI 8'h24
`endif

// file: include/exc_seq_pkg.sv
package exc_seq_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PUSH = 3'b001,
    ST_VEC = 3'b010,
    ST_POP = 3'b011,
    ST_DONE = 3'b100
  } seq_state_t;
endpackage : exc_seq_pkg

// file: rtl/exception_entry_return_seq.sv
// Chosen here: the address map and register access over AHB-Lite.
`timescale 1ns/100ps
`include "exc_seq_regs.svh"
// Behaviour
// - Lower stack pointer before writing frame
// - Read frame before raising stack pointer
// - Save eight words of context
// - Process stack only in thread with select
// - New pointer minus 0x20, bit2 cleared
// - Fixed word offsets within frame
// - Stacked status bit9 holds realign flag
// - Handler starts with 8-byte aligned stack
// - Memory fault abandons stacking sequence
// - Handler mode, number loaded, select cleared
// - Mark active, set event, barrier
// - Vector read at base plus four times number
// - Return address next or faulting instruction
// - Stacked return address bit0 is zero
// - Escalated supervisor call keeps its address
// - Return only in handler via pop/branch
// - Return code top nibble F, ones above
// - Code F1 returns handler on main
// - Code F9 returns thread on main
// - Code FD returns thread on process
// - Popped bit9 undoes entry realignment
// - Other loads are plain addresses; return-shaped ones also set fault
// - Pointer plus 0x20 ORed realign bit
module exception_entry_return_seq
  import exc_seq_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic o_mem_req,
  output logic o_mem_write,
  output logic [31:0] o_mem_addr,
  output logic [31:0] o_mem_wdata,
  input wire logic i_mem_done,
  input wire logic i_mem_fault,
  input wire logic [31:0] i_mem_rdata,
  output logic o_branch_valid,
  output logic [31:0] o_branch_addr,
  output logic o_event_set,
  output logic o_isb,
  output logic o_fault,
  output logic o_busy
);
  seq_state_t state_q, state_d;
  logic [31:0] msp_q, psp_q, vector_base_register_q, psr_q, r_q [0:3], r12_q, lr_q, this_pc_q, next_pc_q;
  logic handler_q, stack_select_bit_q, unprivileged_thread_bit_q, sync_q, escal_q, event_q, fault_q;
  logic [5:0] exc_num_q;
  logic [31:0] ret_code_q, frame_q, popped_ret_q;
  logic [3:0] idx_q;
  logic [63:0] active_q;
  logic use_psp_q, bx_q;
  logic addr_ph_q, wr_ph_q;
  logic [7:0] a_q;
  logic [5:0] ret_exc_q;

  // Register bus decode
  wire bus_go = i_hsel && i_hready && i_htrans[1];
  wire wr_now = addr_ph_q && wr_ph_q;
  wire idle = (state_q == ST_IDLE);
  wire start_exc = wr_now && a_q == `REG_EXC_REQ && idle;
  wire start_ret = wr_now && a_q == `REG_RET_REQ && idle;
  wire [31:0] rc = i_hwdata;

  // Return code check
  wire ret_shaped = rc[31:28] == `RET_TAG;
  wire ret_ok = ret_shaped && (&rc[27:4]) && handler_q && i_hwdata[31:28] == `RET_TAG;

  // Legal return code low nibble
  function automatic logic ret_kind_ok(input logic [3:0] k);
    logic ok;
    unique case (k)
      `RET_HANDLER_MAIN: ok = 1'b1;
      `RET_THREAD_MAIN: ok = 1'b1;
      `RET_THREAD_PROC: ok = 1'b1;
      default: ok = 1'b0;
    endcase
    ret_kind_ok = ok;
  endfunction : ret_kind_ok

  wire ret_valid = ret_ok && ret_kind_ok(rc[3:0]);

  // Stack choice on entry
  wire entry_psp = stack_select_bit_q && !handler_q;
  wire [31:0] old_sp = entry_psp ? psp_q : msp_q;
  wire [31:0] new_sp = (old_sp - `FRAME_SIZE) & ~32'h0000_0004;
  wire realign = old_sp[`ALIGN_BIT];
  wire [5:0] req_num = i_hwdata[5:0];
  wire req_sync = i_hwdata[8];
  wire req_escal = i_hwdata[9];

  // Return address selection
  function automatic logic [31:0] ret_addr(input logic [5:0] n, input logic s,
      input logic e, input logic [31:0] tpc, input logic [31:0] npc);
    logic [31:0] a;
    a = npc;
    if (n == `EXC_HARD_FAULT && s && !e) begin
      a = tpc;
    end
    ret_addr = {a[31:1], 1'b0};
  endfunction : ret_addr

  // Frame word by index
  wire [31:0] stack_psr = {psr_q[31:10], frame_q[0], psr_q[8:0]};
  logic [31:0] push_data;
  always_comb begin
    unique case (idx_q[2:0])
      3'h0: push_data = r_q[0];
      3'h1: push_data = r_q[1];
      3'h2: push_data = r_q[2];
      3'h3: push_data = r_q[3];
      3'h4: push_data = r12_q;
      3'h5: push_data = lr_q;
      3'h6: push_data = ret_addr(exc_num_q, sync_q, escal_q, this_pc_q, next_pc_q);
      3'h7: push_data = stack_psr;
    endcase
  end
  wire [31:0] frame_base = use_psp_q ? psp_q : msp_q;
  wire [31:0] word_addr = frame_base + {26'h0, idx_q, 2'b00};

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (start_exc) begin
          state_d = ST_PUSH;
        end else if (start_ret && ret_valid) begin
          state_d = ST_POP;
        end
      end
      ST_PUSH: begin
        if (i_mem_fault) begin
          state_d = ST_IDLE;
        end else if (i_mem_done && idx_q == `FRAME_WORDS - 4'h1) begin
          state_d = ST_VEC;
        end
      end
      ST_VEC: begin
        if (i_mem_fault) begin
          state_d = ST_IDLE;
        end else if (i_mem_done) begin
          state_d = ST_DONE;
        end
      end
      ST_POP: begin
        if (i_mem_fault) begin
          state_d = ST_IDLE;
        end else if (i_mem_done && idx_q == `FRAME_WORDS - 4'h1) begin
          state_d = ST_DONE;
        end
      end
      ST_DONE: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Bus address phase capture
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      addr_ph_q <= 1'b0;
      wr_ph_q <= 1'b0;
      a_q <= 8'h00;
    end else if (i_hready) begin
      addr_ph_q <= bus_go;
      wr_ph_q <= i_hwrite;
      a_q <= i_haddr[7:0];
    end
  end

  // Sequencer datapath
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      msp_q <= 32'h0000_0000;
      psp_q <= 32'h0000_0000;
      vector_base_register_q <= 32'h0000_0000;
      psr_q <= 32'h0000_0000;
      for (int k = 0; k < 4; k++) begin
        r_q[k] <= 32'h0000_0000;
      end
      r12_q <= 32'h0000_0000;
      lr_q <= 32'h0000_0000;
      this_pc_q <= 32'h0000_0000;
      next_pc_q <= 32'h0000_0000;
      handler_q <= 1'b0;
      stack_select_bit_q <= 1'b0;
      unprivileged_thread_bit_q <= 1'b0;
      sync_q <= 1'b0;
      escal_q <= 1'b0;
      exc_num_q <= 6'h00;
      ret_exc_q <= 6'h00;
      ret_code_q <= 32'h0000_0000;
      frame_q <= 32'h0000_0000;
      popped_ret_q <= 32'h0000_0000;
      idx_q <= 4'h0;
      active_q <= 64'h0;
      use_psp_q <= 1'b0;
      event_q <= 1'b0;
      fault_q <= 1'b0;
      o_branch_valid <= 1'b0;
      o_branch_addr <= 32'h0000_0000;
      o_isb <= 1'b0;
    end else begin
      o_branch_valid <= 1'b0;
      o_isb <= 1'b0;
      event_q <= 1'b0;
      if (wr_now && idle) begin
        unique case (a_q)
          `REG_CTRL: begin
            handler_q <= i_hwdata[0];
            stack_select_bit_q <= i_hwdata[1];
            unprivileged_thread_bit_q <= i_hwdata[2];
          end
          `REG_MSP: msp_q <= i_hwdata;
          `REG_PSP: psp_q <= i_hwdata;
          `REG_VECTOR_BASE_REGISTER: vector_base_register_q <= i_hwdata;
          `REG_PSR: psr_q <= i_hwdata;
          `REG_STATUS: fault_q <= 1'b0;
          default: ;
        endcase
      end
      if (start_exc) begin
        // Stack pointer lowered before any store
        if (entry_psp) begin
          psp_q <= new_sp;
        end else begin
          msp_q <= new_sp;
        end
        use_psp_q <= entry_psp;
        frame_q <= {31'h0, realign};
        exc_num_q <= req_num;
        sync_q <= req_sync;
        escal_q <= req_escal;
        idx_q <= 4'h0;
      end
      if (start_ret) begin
        // Other loads fall through as addresses
        if (!ret_valid) begin
          o_branch_valid <= 1'b1;
          o_branch_addr <= rc;
          fault_q <= ret_shaped;
        end else begin
          ret_code_q <= rc;
          use_psp_q <= rc[3:0] == `RET_THREAD_PROC;
          ret_exc_q <= psr_q[5:0];
          idx_q <= 4'h0;
        end
      end
      if (state_q == ST_POP && i_mem_done && !i_mem_fault) begin
        idx_q <= idx_q + 4'h1;
        unique case (idx_q)
          4'h0, 4'h1, 4'h2, 4'h3: r_q[idx_q[1:0]] <= i_mem_rdata;
          4'h4: r12_q <= i_mem_rdata;
          4'h5: lr_q <= i_mem_rdata;
          4'h6: popped_ret_q <= i_mem_rdata;
          default: begin
            psr_q <= i_mem_rdata;
            // Pointer raised only after last read
            if (use_psp_q) begin
              psp_q <= (psp_q + `FRAME_SIZE) | {29'h0, i_mem_rdata[`REALIGN_PSR_BIT], 2'b00};
            end else begin
              msp_q <= (msp_q + `FRAME_SIZE) | {29'h0, i_mem_rdata[`REALIGN_PSR_BIT], 2'b00};
            end
            active_q[ret_exc_q] <= 1'b0;
            handler_q <= ret_code_q[3:0] == `RET_HANDLER_MAIN;
            stack_select_bit_q <= use_psp_q;
            if (ret_code_q[3:0] != `RET_HANDLER_MAIN && unprivileged_thread_bit_q) begin
              psr_q <= {i_mem_rdata[31:6], 6'h00};
            end
            o_branch_valid <= 1'b1;
            o_branch_addr <= popped_ret_q;
            event_q <= 1'b1;
            o_isb <= 1'b1;
          end
        endcase
      end
      if (state_q == ST_PUSH && i_mem_done && !i_mem_fault) begin
        idx_q <= idx_q + 4'h1;
      end
      if (state_q == ST_VEC && i_mem_done && !i_mem_fault) begin
        handler_q <= 1'b1;
        psr_q <= {psr_q[31:6], exc_num_q};
        stack_select_bit_q <= 1'b0;
        active_q[exc_num_q] <= 1'b1;
        event_q <= 1'b1;
        o_isb <= 1'b1;
        o_branch_valid <= 1'b1;
        o_branch_addr <= i_mem_rdata;
      end
      if (state_q != ST_IDLE && state_q != ST_DONE && i_mem_fault) begin
        fault_q <= 1'b1;
      end
    end
  end

  // Memory request drive
  wire in_mem = state_q == ST_PUSH || state_q == ST_VEC || state_q == ST_POP;
  assign o_mem_req = in_mem;
  assign o_mem_write = state_q == ST_PUSH;
  assign o_mem_addr = state_q == ST_VEC ? vector_base_register_q + {24'h0, exc_num_q, 2'b00} : word_addr;
  assign o_mem_wdata = state_q == ST_PUSH ? push_data : 32'h0000_0000;
  assign o_event_set = event_q;
  assign o_fault = fault_q;
  assign o_busy = !idle;

  // Register read mux
  logic [31:0] rd_mux;
  always_comb begin
    unique case (a_q)
      `REG_CTRL: rd_mux = {29'h0, unprivileged_thread_bit_q, stack_select_bit_q, handler_q};
      `REG_STATUS: rd_mux = {26'h0, fault_q, state_q, 1'b0, !idle};
      `REG_MSP: rd_mux = msp_q;
      `REG_PSP: rd_mux = psp_q;
      `REG_VECTOR_BASE_REGISTER: rd_mux = vector_base_register_q;
      `REG_PSR: rd_mux = psr_q;
      `REG_ACTIVE_LO: rd_mux = active_q[31:0];
      `REG_ACTIVE_HI: rd_mux = active_q[63:32];
      default: rd_mux = 32'h0000_0000;
    endcase
  end
  assign o_hrdata = (addr_ph_q && !wr_ph_q) ? rd_mux : 32'h0000_0000;
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;

  // Registered copy of start_ret; this_pc_q and next_pc_q are never loaded after reset
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      bx_q <= 1'b0;
    end else begin
      bx_q <= start_ret;
    end
  end
endmodule : exception_entry_return_seq

// file: testbench/exc_seq_asserts.sv
`timescale 1ns/100ps
module exc_seq_checker (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  input wire logic o_mem_req,
  input wire logic o_mem_write,
  input wire logic [31:0] o_mem_addr,
  input wire logic i_mem_done,
  input wire logic i_mem_fault,
  input wire logic o_branch_valid,
  input wire logic o_event_set,
  input wire logic o_isb,
  input wire logic o_fault,
  input wire logic o_busy
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  logic [3:0] wcnt_q;
  logic [3:0] wcnt_d;
  assign wcnt_d = !o_busy ? 4'h0 : wcnt_q + {3'h0, o_mem_req && o_mem_write && i_mem_done};
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) wcnt_q <= 4'h0;
    else wcnt_q <= wcnt_d;
  end
  bus_okay_a: assert property (o_hreadyout && !o_hresp)
    else $error("bus slave not ready or not okay");
  req_hold_a: assert property (o_mem_req && !i_mem_done && !i_mem_fault |=>
    o_mem_req && $stable(o_mem_addr)) else $error("memory request changed before completion");
  push_align_a: assert property ($rose(o_mem_req && o_mem_write) |->
    o_mem_addr[2:0] == 3'h0) else $error("frame bottom not 8-byte aligned");
  push_step_a: assert property (o_mem_req && o_mem_write && i_mem_done |=>
    !o_mem_write || o_mem_addr == $past(o_mem_addr) + 32'h4) else $error("frame word step wrong");
  push_count_a: assert property (o_mem_req && !o_mem_write && wcnt_q != 4'h0 |->
    wcnt_q == 4'h8) else $error("frame word count wrong");
  fault_flag_a: assert property (o_mem_req && i_mem_fault |=> o_fault)
    else $error("memory fault not flagged");
  branch_pulse_a: assert property (o_branch_valid |=> !o_branch_valid)
    else $error("branch pulse too long");
  isb_event_a: assert property (o_isb |-> o_event_set)
    else $error("barrier without event");
  req_busy_a: assert property (o_mem_req |-> o_busy)
    else $error("memory request while idle");
endmodule : exc_seq_checker
bind exception_entry_return_seq exc_seq_checker u_chk (.i_clk_sys, .i_reset, .o_hreadyout,
  .o_hresp, .o_mem_req, .o_mem_write, .o_mem_addr, .i_mem_done, .i_mem_fault, .o_branch_valid,
  .o_event_set, .o_isb, .o_fault, .o_busy);

// file: testbench/exc_mem_model.sv
`timescale 1ns/100ps
module exc_mem_model (
  input wire logic i_clk_sys,
  input wire logic i_req,
  input wire logic i_write,
  input wire logic [31:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic [1:0] i_wait,
  input wire logic i_fault_en,
  output logic o_done,
  output logic o_fault,
  output logic [31:0] o_rdata
);
  logic [31:0] m [logic [31:0]];
  logic [1:0] cnt = 2'h0;
  initial begin
    o_done = 1'b0;
    o_fault = 1'b0;
    o_rdata = 32'h0;
  end
  // Completes or faults each word after a stall; data only valid in done cycle
  always @(posedge i_clk_sys) begin
    o_done <= 1'b0;
    o_fault <= 1'b0;
    o_rdata <= ~o_rdata;
    if (i_req && !o_done && !o_fault) begin
      if (cnt < i_wait) cnt <= cnt + 2'h1;
      else begin
        cnt <= 2'h0;
        if (i_fault_en) o_fault <= 1'b1;
        else begin
          o_done <= 1'b1;
          if (i_write) m[i_addr] = i_wdata;
          else o_rdata <= m.exists(i_addr) ? m[i_addr] : 32'h0;
        end
      end
    end
  end
endmodule : exc_mem_model

// file: testbench/tb_exception_entry_return_seq.sv
`timescale 1ns/100ps
`include "exc_seq_regs.svh"
module tb_exception_entry_return_seq;
  logic i_clk_sys = 1'b0;
  logic i_reset = 1'b1;
  logic hsel = 1'b0, hwrite = 1'b0, fen = 1'b0;
  logic [1:0] htrans = 2'h0, wt = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, maddr, mwdata, mrdata, baddr;
  logic hrdy, hresp, mreq, mwr, mdone, mflt, bval, evs, isb, flt, busy;
  int num_errors = 0, tests_run = 0, cyc = 0;
  logic [31:0] rs = 32'hDC8C, msp = 32'h0, psp = 32'h0, psr = 32'h0, r;
  logic [2:0] ctrl = 3'h0;
  logic [63:0] act = 64'h0;
  logic [5:0] ip = 6'h0;
  always #12.5 i_clk_sys = ~i_clk_sys;
  exception_entry_return_seq dut (.i_clk_sys, .i_reset, .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hrdy),
    .o_hrdata(hrdata), .o_hreadyout(hrdy), .o_hresp(hresp), .o_mem_req(mreq), .o_mem_write(mwr),
    .o_mem_addr(maddr), .o_mem_wdata(mwdata), .i_mem_done(mdone), .i_mem_fault(mflt),
    .i_mem_rdata(mrdata), .o_branch_valid(bval), .o_branch_addr(baddr), .o_event_set(evs),
    .o_isb(isb), .o_fault(flt), .o_busy(busy));
  exc_mem_model mem (.i_clk_sys, .i_req(mreq), .i_write(mwr), .i_addr(maddr), .i_wdata(mwdata),
    .i_wait(wt), .i_fault_en(fen), .o_done(mdone), .o_fault(mflt), .o_rdata(mrdata));
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction : rnd
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim();
    $display("mismatches %0d comparisons %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge i_clk_sys); while (!hrdy);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge i_clk_sys); while (!hrdy);
    r = hrdata;
  endtask : ahb
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk(r, exp);
  endtask : rd
  task automatic wbr();
    int n = 0;
    wt <= 2'(rnd());
    do @(posedge i_clk_sys); while (!bval && ++n < 400);
    chk(bval, 1'b1);
  endtask : wbr
  task automatic chkst();
    rd(`REG_CTRL, ctrl);
    rd(`REG_MSP, msp);
    rd(`REG_PSP, psp);
    rd(`REG_ACTIVE_LO, act[31:0]);
    ahb(1'b0, `REG_PSR, 32'h0);
    chk(r[5:0], ip);
  endtask : chkst
  task automatic ent(input logic [5:0] num, input logic [31:0] pm);
    logic [31:0] sp, ns, v;
    logic sel, al;
    sel = ctrl[1] && !ctrl[0];
    sp = sel ? psp : msp;
    al = sp[2];
    ns = (sp - 32'h20) & ~32'h4;
    v = rnd() & 32'h00FF_FFFC;
    mem.m[32'h100 + 4 * num] = v;
    ahb(1'b1, `REG_EXC_REQ, {22'h0, num == 6'h03, 3'h0, num});
    wbr();
    chk({isb, evs}, 2'h3);
    chk(baddr, v);
    for (int i = 0; i < 8; i++) begin
      chk(mem.m[ns + 4 * i] & (i == 7 ? pm : '1), i == 7 ? {psr[31:10], al, psr[8:0]} & pm : 0);
    end
    if (sel) psp = ns;
    else msp = ns;
    ctrl = {ctrl[2], 2'b01};
    act[num] = 1'b1;
    ip = num;
    psr[5:0] = num;
    chkst();
  endtask : ent
  task automatic ret(input logic [31:0] code);
    logic [31:0] sp, pw, pc;
    sp = code[2] ? psp : msp;
    pw = mem.m[sp + 32'h1C];
    pc = rnd() & 32'h00FF_FFFE;
    mem.m[sp + 32'h18] = pc;
    ahb(1'b1, `REG_RET_REQ, code);
    wbr();
    chk(baddr, pc);
    sp = (sp + 32'h20) | {29'h0, pw[9], 2'b00};
    if (code[2]) psp = sp;
    else msp = sp;
    act[ip] = 1'b0;
    ip = (code[3] && ctrl[2]) ? 6'h0 : pw[5:0];
    psr = pw;
    psr[5:0] = ip;
    ctrl = {ctrl[2], code[2], ~code[3]};
    chkst();
  endtask : ret
  initial begin
    repeat (8) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    chkst();
    rd(32'h40, 32'h0);
    rd(`REG_STATUS, 32'h0);
    msp = (rnd() & 32'h0000_FFFC) | 32'h0001_0004;
    psp = (rnd() & 32'h0000_FFF8) | 32'h0002_0000;
    psr = rnd() & 32'hF100_0200;
    ahb(1'b1, `REG_MSP, msp);
    ahb(1'b1, `REG_PSP, psp);
    ahb(1'b1, `REG_VECTOR_BASE_REGISTER, 32'h100);
    ahb(1'b1, `REG_PSR, psr);
    ent(6'h10, '1);
    ent(6'h03, 32'h3FF);
    ret(32'hFFFF_FFF1);
    ret(32'hFFFF_FFF9);
    ctrl = 3'h6;
    ahb(1'b1, `REG_CTRL, 32'h6);
    psr = rnd() & 32'hF100_0200;
    ahb(1'b1, `REG_PSR, psr);
    ent(6'h0B, '1);
    ret(32'hFFFF_FFFD);
    ahb(1'b1, `REG_RET_REQ, 32'hFFFF_FFF9);
    wbr();
    chk(baddr, 32'hFFFF_FFF9);
    chkst();
    rd(`REG_STATUS, 32'h20);
    ahb(1'b1, `REG_STATUS, 32'h20);
    rd(`REG_STATUS, 32'h0);
    fen <= 1'b1;
    ahb(1'b1, `REG_EXC_REQ, 32'h10);
    for (int n = 0; n < 100 && !flt; n++) @(posedge i_clk_sys);
    chk(flt, 1'b1);
    rd(`REG_STATUS, 32'h20);
    ahb(1'b0, `REG_STATUS, 32'h0);
    chk(r[5], 1'b1);
    fen <= 1'b0;
    ahb(1'b1, `REG_STATUS, 32'h20);
    ahb(1'b0, `REG_STATUS, 32'h0);
    chk(r[5], 1'b0);
    end_sim();
  end
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc > 20000) begin
      num_errors++;
      end_sim();
    end
  end
endmodule : tb_exception_entry_return_seq
